// File: design/pdc_pkg.sv
/*
  Constants shared by the sensor end and the host end of the power-down link:
  register map, field positions, reset values and every cycle count except HOLD_CYC, which pdc_host derives.
  Assumes both ends run from a 250 MHz aclk.
*/
package pdc_pkg;
  // --------------------------------------------------------------------------
  // Clocking
  // --------------------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int CNT_W = 25;

  // --------------------------------------------------------------------------
  // Sensor register and power timing
  // --------------------------------------------------------------------------
  localparam logic [6:0] CFG_ADDR = 7'h00;
  localparam int SLEEP_BIT = 6;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam int SLEEP_ENTRY_NS = 1330;
  localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_NS * CLK_MHZ + 999) / 1000;
  localparam int TIMEOUT_MS = 90;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * CLK_MHZ * 1000;
  localparam int SETTLE_US = 610;
  localparam int FRAME_RATE = 1500;
  localparam int FRAME_CYC = (CLK_MHZ * 1000000 + FRAME_RATE - 1) / FRAME_RATE;
  localparam int WAKE_FRAMES = 75;
  localparam int WAKE_MAX_MS = 50;
  localparam int WAKE_MIN_CYC = SETTLE_US * CLK_MHZ + WAKE_FRAMES * FRAME_CYC;
  localparam int WAKE_MAX_CYC = WAKE_MAX_MS * CLK_MHZ * 1000;
  localparam int WAKE_CYC = (WAKE_MIN_CYC < WAKE_MAX_CYC) ? WAKE_MIN_CYC : WAKE_MAX_CYC;
  localparam int PU_FRAMES = 50;
  localparam int PU_MAX_MS = 40;
  localparam int PU_MIN_CYC = SETTLE_US * CLK_MHZ + PU_FRAMES * FRAME_CYC;
  localparam int PU_MAX_CYC = PU_MAX_MS * CLK_MHZ * 1000;
  localparam int PU_CYC = (PU_MIN_CYC < PU_MAX_CYC) ? PU_MIN_CYC : PU_MAX_CYC;

  // --------------------------------------------------------------------------
  // Host link timing
  // --------------------------------------------------------------------------
  localparam int SCK_HALF_NS = 250;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int GAP_US = 100;
  localparam int GAP_CYC = GAP_US * CLK_MHZ;
  localparam int POST_WAKE_MS = 50;
  localparam int POST_WAKE_CYC = POST_WAKE_MS * CLK_MHZ * 1000;

  // --------------------------------------------------------------------------
  // Host registers
  // --------------------------------------------------------------------------
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_SLEEP = 8'h08;
  localparam int CMD_WR_BIT = 7;
  localparam int CMD_DATA_LSB = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DATA_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pdc_pkg

// File: design/pdc_link_if.sv
/*
  Two-wire serial link between host and sensor plus the light-source pin.
  Assumes an external pull-up: an undriven data line reads high.
*/
`timescale 1ns/1ns
`default_nettype none
interface pdc_link_if;
  logic sck;
  logic sdio_h_o;
  logic sdio_h_oe;
  logic sdio_d_o;
  logic sdio_d_oe;
  logic sdio;
  logic led_o;
  logic led_oe;

  // Sensor drive wins; a collision is an out-of-sync fault anyway
  assign sdio = sdio_d_oe ? sdio_d_o : (sdio_h_oe ? sdio_h_o : 1'h1);

  modport sensor (
    input sck,
    input sdio,
    output sdio_d_o,
    output sdio_d_oe,
    output led_o,
    output led_oe
  );
  modport host (
    output sck,
    output sdio_h_o,
    output sdio_h_oe,
    input sdio
  );
endinterface : pdc_link_if
`default_nettype wire

// File: design/pdc_sensor.sv
/*
  Sensor end: serial port on the link clock, configuration register with the
  sleep request bit, power-down sequencing and transaction timeout on aclk.
  Assumes the host drives sck and sends complete 16-bit frames.
*/
`timescale 1ns/1ns
`default_nettype none

module pdc_sensor #(
  parameter int TIMEOUT_CYC = pdc_pkg::TIMEOUT_CYC,
  parameter int WAKE_CYC = pdc_pkg::WAKE_CYC,
  parameter int PU_CYC = pdc_pkg::PU_CYC
) (
  pdc_link_if.sensor l,
  input wire logic aclk,
  input wire logic aresetn,
  output var logic sleep_active,
  output var logic report_ready,
  output var logic analog_enable,
  output var logic port_timeout
);
  typedef enum logic [4:0] {
    PS_PWRUP = 5'h01,
    PS_AWAKE = 5'h02,
    PS_ENTER = 5'h04,
    PS_ASLEEP = 5'h08,
    PS_WAKING = 5'h10
  } pdc_pstate_t;

  localparam logic [pdc_pkg::CNT_W-1:0] TO_LAST = pdc_pkg::CNT_W'(TIMEOUT_CYC - 1);
  localparam logic [pdc_pkg::CNT_W-1:0] WAKE_LAST = pdc_pkg::CNT_W'(WAKE_CYC - 1);
  localparam logic [pdc_pkg::CNT_W-1:0] PU_LAST = pdc_pkg::CNT_W'(PU_CYC - 1);
  localparam logic [pdc_pkg::CNT_W-1:0] ENTRY_LAST = pdc_pkg::CNT_W'(pdc_pkg::SLEEP_ENTRY_CYC - 1);

  logic por_clr_r;
  logic port_clr_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [6:0] addr_r;
  logic wr_r;
  logic busy_r;
  logic [7:0] cfg_r;
  logic sdo_r;
  logic soe_r;
  logic wr_hit;
  logic [7:0] rd_byte;
  logic busy_s1;
  logic busy_s2;
  logic sleep_s1;
  logic sleep_s2;
  logic [pdc_pkg::CNT_W-1:0] to_cnt_r;
  logic to_fire;
  pdc_pstate_t st_r;
  pdc_pstate_t st_nxt;
  logic [pdc_pkg::CNT_W-1:0] st_cnt_r;
  logic led_o_r;
  logic led_oe_r;

  // --------------------------------------------------------------------------
  // Port clears
  // --------------------------------------------------------------------------
  // Both clears come from aclk flops; the link domain sees them only as
  // asynchronous clears, which is safe because sck stands still when they act.
  always_ff @(posedge aclk) begin
    por_clr_r <= ~aresetn;
  end

  always_ff @(posedge aclk) begin
    port_clr_r <= ~aresetn | to_fire;
  end

  // --------------------------------------------------------------------------
  // Serial receive on the link clock
  // --------------------------------------------------------------------------
  always_ff @(posedge l.sck or posedge port_clr_r) begin
    if (port_clr_r) begin
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      addr_r <= 7'h00;
      wr_r <= 1'h0;
      busy_r <= 1'h0;
    end else begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
      shift_r <= {shift_r[6:0], l.sdio};
      busy_r <= (bit_cnt_r != 4'hf);
      if (bit_cnt_r == 4'h7) begin
        wr_r <= shift_r[6];
        addr_r <= {shift_r[5:0], l.sdio};
      end
    end
  end

  // The last data bit arrives with the sixteenth rising edge
  assign wr_hit = (bit_cnt_r == 4'hf) && wr_r && (addr_r == pdc_pkg::CFG_ADDR);

  // --------------------------------------------------------------------------
  // Configuration register
  // --------------------------------------------------------------------------
  // Cleared only at power-on, never by the port timeout, so settings survive
  // sleep and a stalled frame alike.
  always_ff @(posedge l.sck or posedge por_clr_r) begin
    if (por_clr_r) begin
      cfg_r <= pdc_pkg::CFG_RST;
    end else if (wr_hit) begin
      if (cfg_r[pdc_pkg::SLEEP_BIT]) begin
        cfg_r[pdc_pkg::SLEEP_BIT] <= shift_r[pdc_pkg::SLEEP_BIT-1];
      end else begin
        cfg_r <= {shift_r[6:0], l.sdio};
      end
    end
  end

  // Unknown addresses read as zero
  assign rd_byte = (addr_r == pdc_pkg::CFG_ADDR) ? cfg_r : 8'h00;

  // --------------------------------------------------------------------------
  // Serial transmit on falling edges
  // --------------------------------------------------------------------------
  // D0 stays on the line until the first falling edge of the next frame.
  always_ff @(negedge l.sck or posedge port_clr_r) begin
    if (port_clr_r) begin
      sdo_r <= 1'h0;
      soe_r <= 1'h0;
    end else begin
      sdo_r <= rd_byte[~bit_cnt_r[2:0]];
      soe_r <= ~wr_r & bit_cnt_r[3] & ~cfg_r[pdc_pkg::SLEEP_BIT];
    end
  end

  assign l.sdio_d_o = sdo_r;
  assign l.sdio_d_oe = soe_r;

  // --------------------------------------------------------------------------
  // Crossings into aclk
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_s1 <= 1'h0;
      busy_s2 <= 1'h0;
      sleep_s1 <= 1'h0;
      sleep_s2 <= 1'h0;
    end else begin
      busy_s1 <= busy_r;
      busy_s2 <= busy_s1;
      sleep_s1 <= cfg_r[pdc_pkg::SLEEP_BIT];
      sleep_s2 <= sleep_s1;
    end
  end

  // --------------------------------------------------------------------------
  // Transaction timeout
  // --------------------------------------------------------------------------
  // Frozen while the sleep bit is set: a partial frame then hangs the port.
  assign to_fire = busy_s2 && !sleep_s2 && (to_cnt_r == TO_LAST);

  always_ff @(posedge aclk) begin
    if (!aresetn || !busy_s2 || sleep_s2 || to_fire) begin
      to_cnt_r <= '0;
    end else begin
      to_cnt_r <= to_cnt_r + 1'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_timeout <= 1'h0;
    end else begin
      port_timeout <= to_fire;
    end
  end

  // --------------------------------------------------------------------------
  // Power sequencing
  // --------------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      PS_PWRUP: begin
        if (st_cnt_r == PU_LAST) begin
          st_nxt = sleep_s2 ? PS_ENTER : PS_AWAKE;
        end
      end
      PS_AWAKE: begin
        if (sleep_s2) begin
          st_nxt = PS_ENTER;
        end
      end
      PS_ENTER: begin
        if (!sleep_s2) begin
          st_nxt = PS_AWAKE;
        end else if (st_cnt_r == ENTRY_LAST) begin
          st_nxt = PS_ASLEEP;
        end
      end
      PS_ASLEEP: begin
        if (!sleep_s2) begin
          st_nxt = PS_WAKING;
        end
      end
      PS_WAKING: begin
        if (sleep_s2) begin
          st_nxt = PS_ENTER;
        end else if (st_cnt_r == WAKE_LAST) begin
          st_nxt = PS_AWAKE;
        end
      end
      default: begin
        st_nxt = PS_PWRUP;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= PS_PWRUP;
      st_cnt_r <= '0;
    end else begin
      st_r <= st_nxt;
      st_cnt_r <= (st_nxt != st_r) ? '0 : st_cnt_r + 1'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_active <= 1'h0;
      report_ready <= 1'h0;
      analog_enable <= 1'h1;
      led_o_r <= 1'h1;
      led_oe_r <= 1'h1;
    end else begin
      sleep_active <= (st_nxt == PS_ASLEEP);
      report_ready <= (st_nxt == PS_AWAKE);
      analog_enable <= (st_nxt != PS_ASLEEP);
      led_o_r <= (st_nxt != PS_ASLEEP);
      led_oe_r <= (st_nxt != PS_ASLEEP);
    end
  end

  assign l.led_o = led_o_r;
  assign l.led_oe = led_oe_r;
endmodule : pdc_sensor
`default_nettype wire

// File: design/pdc_host.sv
/*
  Host end: AXI4-Lite register slave that turns software orders into
  complete serial frames, generates sck by division and keeps the spacing
  the sensor needs between frames.
  Assumes a single AXI4-Lite master and the sensor on the other link end.
*/
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module pdc_host #(
  parameter int GAP_CYC = pdc_pkg::GAP_CYC,
  parameter int POST_WAKE_CYC = pdc_pkg::POST_WAKE_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic [7:0] awaddr,
  output var logic awready,
  input wire logic wvalid,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output var logic wready,
  output var logic bvalid,
  input wire logic bready,
  output var logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic [7:0] araddr,
  output var logic arready,
  output var logic rvalid,
  input wire logic rready,
  output var logic [31:0] rdata,
  output var logic [1:0] rresp,
  pdc_link_if.host l
);
  typedef enum logic [4:0] {
    H_IDLE = 5'h01,
    H_LOW = 5'h02,
    H_HIGH = 5'h04,
    H_PREP = 5'h08,
    H_GAP = 5'h10
  } pdc_hstate_t;

  localparam int HOLD_CYC = (GAP_CYC > pdc_pkg::SLEEP_ENTRY_CYC) ? GAP_CYC : pdc_pkg::SLEEP_ENTRY_CYC;
  localparam logic [pdc_pkg::CNT_W-1:0] HALF_LAST = pdc_pkg::CNT_W'(pdc_pkg::SCK_HALF_CYC - 1);
  localparam logic [pdc_pkg::CNT_W-1:0] PREP_LAST = pdc_pkg::CNT_W'(GAP_CYC - 1);
  localparam logic [pdc_pkg::CNT_W-1:0] HOLD_LAST = pdc_pkg::CNT_W'(HOLD_CYC - 1);
  localparam logic [pdc_pkg::CNT_W-1:0] WAKE_LAST = pdc_pkg::CNT_W'(POST_WAKE_CYC - 1);

  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_do;
  logic busy;
  logic [7:0] cmd_data;
  logic [7:0] cfg_new;
  logic go_r;
  logic go_wake_r;
  logic [15:0] go_word_r;
  logic [7:0] shadow_r;
  pdc_hstate_t hs_r;
  logic [pdc_pkg::CNT_W-1:0] hcnt_r;
  logic [3:0] bi_r;
  logic [15:0] word_r;
  logic rd_r;
  logic wake_gap_r;
  logic sck_r;
  logic sdo_r;
  logic soe_r;
  logic [7:0] rx_r;
  logic sdi_s1;
  logic sdi_s2;

  // --------------------------------------------------------------------------
  // AXI4-Lite write channels
  // --------------------------------------------------------------------------
  assign wr_do = !awready && !wready && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'h1;
      wready <= 1'h1;
      bvalid <= 1'h0;
      bresp <= pdc_pkg::RESP_OKAY;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'h0;
        awaddr_r <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'h0;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (bvalid && bready) begin
        bvalid <= 1'h0;
        awready <= 1'h1;
        wready <= 1'h1;
      end else if (wr_do) begin
        bvalid <= 1'h1;
        bresp <= (awaddr_r == pdc_pkg::REG_CMD || awaddr_r == pdc_pkg::REG_STAT ||
                  awaddr_r == pdc_pkg::REG_SLEEP) ? pdc_pkg::RESP_OKAY : pdc_pkg::RESP_SLVERR;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Orders from software
  // --------------------------------------------------------------------------
  // The shadow mirrors the sensor: while asleep only the sleep bit moves.
  assign busy = (hs_r != H_IDLE) || go_r;
  assign cmd_data = wdata_r[pdc_pkg::CMD_DATA_LSB +: 8];
  assign cfg_new = shadow_r[pdc_pkg::SLEEP_BIT] ?
                   {shadow_r[7], cmd_data[pdc_pkg::SLEEP_BIT], shadow_r[5:0]} : cmd_data;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      go_r <= 1'h0;
      go_wake_r <= 1'h0;
      go_word_r <= 16'h0;
      shadow_r <= pdc_pkg::CFG_RST;
    end else begin
      go_r <= 1'h0;
      if (wr_do && !busy) begin
        if (awaddr_r == pdc_pkg::REG_CMD && wstrb_r[1:0] == 2'h3) begin
          go_r <= 1'h1;
          go_word_r <= {wdata_r[pdc_pkg::CMD_WR_BIT], wdata_r[6:0], cmd_data};
          go_wake_r <= 1'h0;
          if (wdata_r[pdc_pkg::CMD_WR_BIT] && wdata_r[6:0] == pdc_pkg::CFG_ADDR) begin
            shadow_r <= cfg_new;
            go_wake_r <= shadow_r[pdc_pkg::SLEEP_BIT] & ~cmd_data[pdc_pkg::SLEEP_BIT];
          end
        end else if (awaddr_r == pdc_pkg::REG_SLEEP && wstrb_r[0]) begin
          go_r <= 1'h1;
          go_word_r <= {1'h1, pdc_pkg::CFG_ADDR, shadow_r[7], wdata_r[0], shadow_r[5:0]};
          shadow_r[pdc_pkg::SLEEP_BIT] <= wdata_r[0];
          go_wake_r <= shadow_r[pdc_pkg::SLEEP_BIT] & ~wdata_r[0];
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite read channels
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'h1;
      rvalid <= 1'h0;
      rdata <= 32'h0;
      rresp <= pdc_pkg::RESP_OKAY;
    end else if (rvalid && rready) begin
      rvalid <= 1'h0;
      arready <= 1'h1;
    end else if (arvalid && arready) begin
      arready <= 1'h0;
      rvalid <= 1'h1;
      rresp <= pdc_pkg::RESP_OKAY;
      rdata <= 32'h0;
      if (araddr == pdc_pkg::REG_STAT) begin
        rdata[pdc_pkg::STAT_DATA_LSB +: 8] <= rx_r;
        rdata[pdc_pkg::STAT_BUSY_BIT] <= busy;
      end else if (araddr == pdc_pkg::REG_SLEEP) begin
        rdata[7:0] <= shadow_r;
      end else if (araddr != pdc_pkg::REG_CMD) begin
        rresp <= pdc_pkg::RESP_SLVERR;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Serial frame engine
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sdi_s1 <= 1'h1;
      sdi_s2 <= 1'h1;
    end else begin
      sdi_s1 <= l.sdio;
      sdi_s2 <= sdi_s1;
    end
  end

  // A frame once started always runs to sixteen bits; nothing aborts it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hs_r <= H_IDLE;
      hcnt_r <= '0;
      bi_r <= 4'h0;
      word_r <= 16'h0;
      rd_r <= 1'h0;
      wake_gap_r <= 1'h0;
      sck_r <= 1'h1;
      sdo_r <= 1'h1;
      soe_r <= 1'h0;
      rx_r <= 8'h00;
    end else begin
      hcnt_r <= hcnt_r + 1'h1;
      unique case (hs_r)
        H_IDLE: begin
          hcnt_r <= '0;
          if (go_r) begin
            word_r <= go_word_r;
            rd_r <= ~go_word_r[15];
            wake_gap_r <= go_wake_r;
            bi_r <= 4'h0;
            sck_r <= 1'h0;
            sdo_r <= go_word_r[15];
            soe_r <= 1'h1;
            hs_r <= H_LOW;
          end
        end
        H_LOW: begin
          if (hcnt_r == HALF_LAST) begin
            hcnt_r <= '0;
            sck_r <= 1'h1;
            hs_r <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (hcnt_r == HALF_LAST) begin
            hcnt_r <= '0;
            if (rd_r && bi_r[3]) begin
              rx_r <= {rx_r[6:0], sdi_s2};
            end
            if (bi_r == 4'hf) begin
              soe_r <= 1'h0;
              hs_r <= H_GAP;
            end else if (rd_r && bi_r == 4'h7) begin
              soe_r <= 1'h0;
              bi_r <= 4'h8;
              hs_r <= H_PREP;
            end else begin
              bi_r <= bi_r + 4'h1;
              sck_r <= 1'h0;
              sdo_r <= word_r[14];
              word_r <= {word_r[14:0], 1'h0};
              hs_r <= H_LOW;
            end
          end
        end
        H_PREP: begin
          if (hcnt_r == PREP_LAST) begin
            hcnt_r <= '0;
            sck_r <= 1'h0;
            hs_r <= H_LOW;
          end
        end
        H_GAP: begin
          if (hcnt_r == (wake_gap_r ? WAKE_LAST : HOLD_LAST)) begin
            hs_r <= H_IDLE;
          end
        end
        default: begin
          hs_r <= H_IDLE;
        end
      endcase
    end
  end

  assign l.sck = sck_r;
  assign l.sdio_h_o = sdo_r;
  assign l.sdio_h_oe = soe_r;
endmodule : pdc_host
`default_nettype wire

// File: bench/pdc_monitor.sv
/*
  Checker of the host-sensor link: framing, line ownership, sleep timing.
  Assumes the host derives sck from aclk.
*/
`timescale 1ns/1ns
`default_nettype none
module pdc_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sck,
  input wire logic sdio_h_o,
  input wire logic sdio_h_oe,
  input wire logic sdio_d_oe,
  input wire logic sdio,
  input wire logic led_oe
);
  // ---------------------------------------------------------------------------
  // Frame capture
  // ---------------------------------------------------------------------------
  logic [14:0] shf_r;
  logic [3:0] nbit_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shf_r <= 15'h0;
      nbit_r <= 4'h0;
    end else if ($rose(sck)) begin
      shf_r <= {shf_r[13:0], sdio};
      nbit_r <= nbit_r + 4'h1;
    end
  end
  logic [8:0] ent_r;
  always_ff @(posedge aclk) begin
    if (!aresetn || ent_r == 9'h140) begin
      ent_r <= 9'h0;
    end else if (ent_r != 9'h0 || ($rose(sck) && nbit_r == 4'hf && shf_r[14:7] == 8'h80 && shf_r[5] && led_oe)) begin
      ent_r <= ent_r + 9'h1;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Last rising sck of a config write with bit six b
  sequence s_cfg_wr(b);
    $rose(sck) && nbit_r == 4'hf && shf_r[14:7] == 8'h80 && shf_r[5] == b;
  endsequence
  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  property p_low_half;
    $fell(sck) |-> ##62 !sck ##1 sck;
  endproperty
  a_low_half: assert property (p_low_half)
    else $error("sck low half is not 63 cycles");
  property p_host_shift;
    sdio_h_oe && $past(sdio_h_oe) && $changed(sdio_h_o) |-> $fell(sck);
  endproperty
  a_host_shift: assert property (p_host_shift)
    else $error("host data changed off a falling sck");
  property p_no_collide;
    sdio_d_oe |-> !sdio_h_oe;
  endproperty
  a_no_collide: assert property (p_no_collide)
    else $error("both ends drive the data line");
  property p_drive_start;
    $rose(sdio_d_oe) |-> $fell(sck) && nbit_r == 4'h8;
  endproperty
  a_drive_start: assert property (p_drive_start)
    else $error("sensor drives outside the data byte");
  property p_asleep_quiet;
    !led_oe |-> !sdio_d_oe;
  endproperty
  a_asleep_quiet: assert property (p_asleep_quiet)
    else $error("data line driven while asleep");
  property p_sleep_entry;
    ent_r == 9'h140 |-> led_oe ##[1:25] !led_oe;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("sleep entry timing wrong");
  property p_wake;
    s_cfg_wr(1'b0) ##0 !led_oe |-> ##[1:10] led_oe;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake after bit six cleared");
  property p_sleep_stays;
    s_cfg_wr(1'b1) ##0 !led_oe |=> !led_oe [*8];
  endproperty
  a_sleep_stays: assert property (p_sleep_stays)
    else $error("asleep write woke the sensor");
endmodule : pdc_monitor
`default_nettype wire

// File: bench/power_down_control_bench.sv
/*
  Bench: AXI4-Lite orders via the host end to one sensor; a second sensor
  is driven bit by bit for stalls and masked writes.
  Assumes the design files compile first.
*/
`timescale 1ns/1ns
`default_nettype none
module power_down_control_bench;
  localparam int TO = 3000;
  localparam int PU = 300;
  logic aclk, aresetn, awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready, awready, wready, arready;
  logic [7:0] awaddr, araddr, rb;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic slp0, rdy0, ana0, tmo0, slp1, rdy1, ana1, tmo1;
  int fails, n_compared, n;
  bit hit;
  pdc_link_if l0();
  pdc_link_if l1();
  pdc_host #(.GAP_CYC(200), .POST_WAKE_CYC(600)) i_pdc_host (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awaddr(awaddr), .awready(awready), .wvalid(wvalid), .wdata(wdata), .wstrb(wstrb),
    .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .araddr(araddr),
    .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .l(l0.host));
  pdc_sensor #(.TIMEOUT_CYC(TO), .WAKE_CYC(500), .PU_CYC(PU)) i_pdc_sensor (.l(l0.sensor), .aclk(aclk),
    .aresetn(aresetn), .sleep_active(slp0), .report_ready(rdy0), .analog_enable(ana0), .port_timeout(tmo0));
  pdc_sensor #(.TIMEOUT_CYC(TO), .WAKE_CYC(500), .PU_CYC(PU)) i_pdc_sensor_2 (.l(l1.sensor), .aclk(aclk),
    .aresetn(aresetn), .sleep_active(slp1), .report_ready(rdy1), .analog_enable(ana1), .port_timeout(tmo1));
  pdc_monitor i_pdc_monitor (.aclk(aclk), .aresetn(aresetn), .sck(l0.sck), .sdio_h_o(l0.sdio_h_o),
    .sdio_h_oe(l0.sdio_h_oe), .sdio_d_oe(l0.sdio_d_oe), .sdio(l0.sdio), .led_oe(l0.led_oe));
  initial begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end
  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test;
    if (fails == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awvalid <= 1'h1;
    awaddr <= a;
    wvalid <= 1'h1;
    wdata <= v;
    bready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'h0;
        break;
      end
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    arvalid <= 1'h1;
    araddr <= a;
    rready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        break;
      end
    end
  endtask : axi_rd
  task automatic wait_idle;
    repeat (3000) begin
      axi_rd(pdc_pkg::REG_STAT);
      if (d[pdc_pkg::STAT_BUSY_BIT] === 1'h0) break;
    end
    chk(d[pdc_pkg::STAT_BUSY_BIT], 1'h0);
  endtask : wait_idle
  // Serial order via the host; read byte in d[15:8]
  task automatic cmd(input logic w, input logic [6:0] a, input logic [7:0] v);
    axi_wr(pdc_pkg::REG_CMD, {16'h0, v, w, a});
    wait_idle();
    axi_rd(pdc_pkg::REG_STAT);
  endtask : cmd
  task automatic wait_flag(input int i, input logic v, input int lim);
    logic [4:0] f;
    n = 0;
    hit = 1'b0;
    while (n < lim && !hit) begin
      @(posedge aclk);
      f = {tmo1, slp1, rdy1, slp0, rdy0};
      hit = (f[i] === v);
      n++;
    end
  endtask : wait_flag
  // Host on the second link; nb below 16 stalls the frame
  task automatic bang(input logic [15:0] f, input int nb);
    int i;
    rb = 8'h00;
    #1;
    for (i = 0; i < nb; i++) begin
      if (i == 8 && !f[15]) begin
        l1.sdio_h_oe = 1'h0;
        repeat (100) @(posedge aclk);
        #1;
      end
      l1.sck = 1'h0;
      if (f[15] || i < 8) begin
        l1.sdio_h_oe = 1'h1;
        l1.sdio_h_o = f[15 - i];
      end
      #3;
      rb = {rb[6:0], l1.sdio};
      l1.sck = 1'h1;
      #3;
    end
    l1.sdio_h_oe = 1'h0;
    repeat (400) @(posedge aclk);
  endtask : bang
  // ---------------------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    l1.sck = 1'h1;
    l1.sdio_h_o = 1'h1;
    l1.sdio_h_oe = 1'h0;
    fails = 0;
    n_compared = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    wait_flag(0, 1'h1, 1000);
    chk(n >= PU && n <= PU + 3, 1'h1);
    chk(rdy1, 1'h1);
    axi_rd(pdc_pkg::REG_SLEEP);
    chk(d, {24'h0, pdc_pkg::CFG_RST});
    axi_rd(8'h0c);
    chk(d, 32'h0);
    chk(r, pdc_pkg::RESP_SLVERR);
    axi_wr(8'h0c, 32'h1);
    chk(r, pdc_pkg::RESP_SLVERR);
    cmd(1'h1, pdc_pkg::CFG_ADDR, 8'h15);
    cmd(1'h0, pdc_pkg::CFG_ADDR, 8'h00);
    chk(d[15:8], 8'h15);
    cmd(1'h0, 7'h01, 8'h00);
    chk(d[15:8], 8'h00);
    axi_wr(pdc_pkg::REG_SLEEP, 32'h1);
    wait_flag(1, 1'h1, 3000);
    chk({hit, ana0, l0.led_oe}, 3'h4);
    wait_idle();
    cmd(1'h1, pdc_pkg::CFG_ADDR, 8'h7f);
    cmd(1'h0, pdc_pkg::CFG_ADDR, 8'h00);
    chk(d[15:8], 8'hff);
    // Asleep write of zero: only bit six lands, so it wakes
    axi_wr(pdc_pkg::REG_CMD, 32'h80);
    wait_flag(1, 1'h0, 3000);
    chk({hit, rdy0}, 2'h2);
    wait_flag(0, 1'h1, 600);
    chk(hit && n > 450 && n <= 520, 1'h1);
    wait_idle();
    cmd(1'h0, pdc_pkg::CFG_ADDR, 8'h00);
    chk(d[15:8], 8'h15);
    bang(16'h8000, 8);
    wait_flag(4, 1'h1, TO);
    chk(hit && n > TO - 600, 1'h1);
    bang(16'h8003, 16);
    bang(16'h8043, 16);
    wait_flag(3, 1'h1, 1000);
    chk({hit, ana1, l1.led_oe}, 3'h4);
    bang(16'h807c, 16);
    chk(slp1, 1'h1);
    bang(16'h8000, 16);
    wait_flag(3, 1'h0, 1000);
    chk(hit, 1'h1);
    bang(16'h0000, 16);
    chk(rb, 8'h03);
    bang(16'h8043, 16);
    bang(16'h8000, 8);
    wait_flag(4, 1'h1, TO + 500);
    chk(hit, 1'h0);
    end_of_test();
  end
  initial begin
    repeat (100000) @(posedge aclk);
    fails++;
    end_of_test();
  end
endmodule : power_down_control_bench
`default_nettype wire
